// File: hspm_pkg.sv
// hspm_pkg: shared constants of the host-to-sdram page mapper
// assumes: 16-bit register port, 21-bit host byte address, 26-bit sdram byte address
package hspm_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 16;
  localparam int unsigned HOST_AW = 21;
  localparam int unsigned SDRAM_AW = 26;
  localparam int unsigned NUM_WIN = 4;
  localparam int unsigned WIN_SEL_W = 2;
  localparam int unsigned OFS_W = 18;
  localparam int unsigned BASE_W = 8;

  localparam logic [REG_AW-1:0] OFS_RSVD_LO = 8'h2c;
  localparam logic [REG_AW-1:0] OFS_RSVD_HI = 8'h2e;
  localparam logic [REG_AW-1:0] OFS_WIN0_BASE = 8'h30;
  localparam logic [REG_AW-1:0] OFS_WIN1_BASE = 8'h32;
  localparam logic [REG_AW-1:0] OFS_WIN2_BASE = 8'h34;
  localparam logic [REG_AW-1:0] OFS_WIN3_BASE = 8'h36;
  localparam logic [REG_AW-1:0] OFS_RA_CTRL = 8'h38;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h3a;
  localparam logic [REG_AW-1:0] WIN_STRIDE = 8'h02;

  localparam int unsigned BASE_LSB = 2;
  localparam int unsigned BASE_MSB = 9;
  localparam int unsigned RA_DIS_BIT = 15;

  localparam logic [BASE_W-1:0] BASE_RST = 8'h00;
  localparam logic RA_DIS_RST = 1'b0;

  // windowed space is 100000h..1fffffh: top host address bit set
  localparam logic [HOST_AW-1:0] WIN_SPACE_LO = 21'h100000;
  localparam logic [HOST_AW-1:0] WIN_SPACE_HI = 21'h1fffff;
  localparam logic [HOST_AW-1:0] WIN_SIZE = 21'h040000;
endpackage : hspm_pkg

// File: hspm_map_if.sv
// hspm_map_if: carries a host address and the page bases to the window decoder
// assumes: decoder is purely combinational, same clock as the main module
interface hspm_map_if;
  logic [hspm_pkg::HOST_AW-1:0] host_addr;
  logic [hspm_pkg::NUM_WIN-1:0][hspm_pkg::BASE_W-1:0] page_base;
  logic hit;
  logic [hspm_pkg::WIN_SEL_W-1:0] win;
  logic [hspm_pkg::SDRAM_AW-1:0] sdram_addr;

  modport ctrl (output host_addr, output page_base, input hit, input win, input sdram_addr);
  modport dec (input host_addr, input page_base, output hit, output win, output sdram_addr);
endinterface : hspm_map_if

// File: hspm_win_dec.sv
// hspm_win_dec: decodes a host address into one of four windows and the sdram address
// assumes: bases and address are stable for the cycle they are sampled
module hspm_win_dec (
  hspm_map_if.dec m
);
  logic [hspm_pkg::NUM_WIN-1:0] win_hit;
  logic [hspm_pkg::BASE_W-1:0] sel_base;

  // one range comparator per window
  genvar g;
  generate
    for (g = 0; g < hspm_pkg::NUM_WIN; g++) begin : g_win
      localparam logic [hspm_pkg::HOST_AW-1:0] LO =
        hspm_pkg::HOST_AW'(hspm_pkg::WIN_SPACE_LO + hspm_pkg::HOST_AW'(g) * hspm_pkg::WIN_SIZE);
      localparam logic [hspm_pkg::HOST_AW-1:0] HI =
        hspm_pkg::HOST_AW'(LO + hspm_pkg::WIN_SIZE - hspm_pkg::HOST_AW'(1));
      assign win_hit[g] = (m.host_addr >= LO) && (m.host_addr <= HI);
    end
  endgenerate

  always_comb begin
    m.win = '0;
    for (int i = 0; i < hspm_pkg::NUM_WIN; i++) begin
      if (win_hit[i]) begin
        m.win = hspm_pkg::WIN_SEL_W'(i);
      end
    end
  end

  assign m.hit = |win_hit;
  assign sel_base = m.page_base[m.win];
  assign m.sdram_addr = {sel_base, m.host_addr[hspm_pkg::OFS_W-1:0]};
endmodule : hspm_win_dec

// File: hspm_mapper.sv
// hspm_mapper: maps four 256k host windows onto relocatable sdram pages
// assumes: sdram controller takes a request every cycle; register port is single-cycle
//
// Decided for this implementation: the plain strobed port.
module hspm_mapper (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [hspm_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [hspm_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [hspm_pkg::REG_DW-1:0] o_reg_rdata,
  input wire logic i_host_req,
  input wire logic i_host_we,
  input wire logic [hspm_pkg::HOST_AW-1:0] i_host_addr,
  output logic o_sdram_req,
  output logic o_sdram_we,
  output logic [hspm_pkg::SDRAM_AW-1:0] o_sdram_addr,
  output logic o_sdram_read_ahead,
  output logic o_host_unmapped
);
  logic [hspm_pkg::NUM_WIN-1:0][hspm_pkg::BASE_W-1:0] page_base_ff;
  logic ra_dis_ff;
  logic last_hit_ff;
  logic [hspm_pkg::WIN_SEL_W-1:0] last_win_ff;
  logic unmapped_seen_ff;
  logic [hspm_pkg::REG_DW-1:0] nxt_rdata;

  hspm_map_if map_if ();

  hspm_win_dec u_dec (
    .m (map_if)
  );

  assign map_if.host_addr = i_host_addr;
  assign map_if.page_base = page_base_ff;

  // page base registers: only bits 9-2 are stored, writes elsewhere ignored
  genvar g;
  generate
    for (g = 0; g < hspm_pkg::NUM_WIN; g++) begin : g_base
      localparam logic [hspm_pkg::REG_AW-1:0] OFS =
        hspm_pkg::REG_AW'(hspm_pkg::OFS_WIN0_BASE + hspm_pkg::REG_AW'(g) * hspm_pkg::WIN_STRIDE);
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          page_base_ff[g] <= hspm_pkg::BASE_RST;
        end else if (i_reg_wr && i_reg_addr == OFS) begin
          page_base_ff[g] <= i_reg_wdata[hspm_pkg::BASE_MSB:hspm_pkg::BASE_LSB];
        end
      end
    end
  endgenerate

  // read-ahead control: reserved bits are not stored and read back as zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ra_dis_ff <= hspm_pkg::RA_DIS_RST;
    end else if (i_reg_wr && i_reg_addr == hspm_pkg::OFS_RA_CTRL) begin
      ra_dis_ff <= i_reg_wdata[hspm_pkg::RA_DIS_BIT];
    end
  end

  // read mux; reserved 2ch-2eh and unmapped offsets read zero
  always_comb begin
    nxt_rdata = '0;
    case (i_reg_addr)
      hspm_pkg::OFS_WIN0_BASE: begin
        nxt_rdata[hspm_pkg::BASE_MSB:hspm_pkg::BASE_LSB] = page_base_ff[0];
      end
      hspm_pkg::OFS_WIN1_BASE: begin
        nxt_rdata[hspm_pkg::BASE_MSB:hspm_pkg::BASE_LSB] = page_base_ff[1];
      end
      hspm_pkg::OFS_WIN2_BASE: begin
        nxt_rdata[hspm_pkg::BASE_MSB:hspm_pkg::BASE_LSB] = page_base_ff[2];
      end
      hspm_pkg::OFS_WIN3_BASE: begin
        nxt_rdata[hspm_pkg::BASE_MSB:hspm_pkg::BASE_LSB] = page_base_ff[3];
      end
      hspm_pkg::OFS_RA_CTRL: begin
        nxt_rdata[hspm_pkg::RA_DIS_BIT] = ra_dis_ff;
      end
      hspm_pkg::OFS_STATUS: begin
        nxt_rdata[3:0] = {unmapped_seen_ff, last_hit_ff, last_win_ff};
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= nxt_rdata;
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // host access forwarding, one cycle of latency
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_sdram_req <= 1'b0;
      o_sdram_we <= 1'b0;
      o_sdram_addr <= '0;
      o_sdram_read_ahead <= 1'b0;
      o_host_unmapped <= 1'b0;
    end else begin
      o_sdram_req <= i_host_req && map_if.hit;
      o_sdram_we <= i_host_req && map_if.hit && i_host_we;
      o_host_unmapped <= i_host_req && !map_if.hit;
      o_sdram_read_ahead <= i_host_req && map_if.hit && !i_host_we && !ra_dis_ff;
      if (i_host_req && map_if.hit) begin
        o_sdram_addr <= map_if.sdram_addr;
      end
    end
  end

  // status: last window used; sticky unmapped flag cleared by status read, set wins
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      last_hit_ff <= 1'b0;
      last_win_ff <= '0;
      unmapped_seen_ff <= 1'b0;
    end else begin
      if (i_host_req && map_if.hit) begin
        last_hit_ff <= 1'b1;
        last_win_ff <= map_if.win;
      end
      if (i_host_req && !map_if.hit) begin
        unmapped_seen_ff <= 1'b1;
      end else if (i_reg_rd && i_reg_addr == hspm_pkg::OFS_STATUS) begin
        unmapped_seen_ff <= 1'b0;
      end
    end
  end

  a_base_store: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == hspm_pkg::OFS_WIN2_BASE ##1 i_reg_rd
      && i_reg_addr == hspm_pkg::OFS_WIN2_BASE
    |=> o_reg_rdata == {6'h00, $past(i_reg_wdata[9:2], 2), 2'h0})
    else $error("page base readback differs from written bits 9-2");

  a_win_span: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr[20] |=> o_sdram_req
      && o_sdram_addr[17:0] == $past(i_host_addr[17:0]))
    else $error("windowed access not forwarded within its 256k page");

  a_win0_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr >= 21'h100000 && i_host_addr <= 21'h13ffff
    |=> o_sdram_addr[25:18] == $past(page_base_ff[0]))
    else $error("window 0 access used wrong base");

  a_win1_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr >= 21'h140000 && i_host_addr <= 21'h17ffff
    |=> o_sdram_addr[25:18] == $past(page_base_ff[1]))
    else $error("window 1 access used wrong base");

  a_win2_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr >= 21'h180000 && i_host_addr <= 21'h1bffff
    |=> o_sdram_addr[25:18] == $past(page_base_ff[2]))
    else $error("window 2 access used wrong base");

  a_win3_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr >= 21'h1c0000 && i_host_addr <= 21'h1fffff
    |=> o_sdram_addr[25:18] == $past(page_base_ff[3]))
    else $error("window 3 access used wrong base");

  a_addr_join: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && i_host_addr[20] |=> o_sdram_addr
      == {$past(page_base_ff[i_host_addr[19:18]]), $past(i_host_addr[17:0])})
    else $error("sdram address not base joined to host offset");

  a_ra_disable: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_sdram_read_ahead == (o_sdram_req && !o_sdram_we && !$past(ra_dis_ff)))
    else $error("read-ahead hint disagrees with access kind or disable bit");

  a_ra_store: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == hspm_pkg::OFS_RA_CTRL
    |=> ra_dis_ff == $past(i_reg_wdata[hspm_pkg::RA_DIS_BIT]))
    else $error("read-ahead disable bit not taken from write data");

  a_base_rsvd: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == hspm_pkg::OFS_WIN0_BASE
    |=> o_reg_rdata[15:10] == 6'h00 && o_reg_rdata[1:0] == 2'h0)
    else $error("page base readback shows bits outside 9-2");

  a_ra_rsvd: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == hspm_pkg::OFS_RA_CTRL |=> o_reg_rdata[14:0] == 15'h0000)
    else $error("read-ahead control readback shows reserved bits");

  a_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("read data present without a read strobe");

  a_last_win: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) i_host_req && i_host_addr[20]
    |=> last_hit_ff && last_win_ff == $past(i_host_addr[19:18]))
    else $error("status does not name the window of the last access");

  a_miss_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && !i_host_addr[20] |=> $stable(o_sdram_addr))
    else $error("access outside windows moved the sdram address");

  a_unmapped_sticky: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && !i_host_addr[20] |=> unmapped_seen_ff)
    else $error("unmapped flag lost when a miss met the clearing read");

  a_unmapped_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_host_req && !i_host_addr[20] |=> o_host_unmapped && !o_sdram_req)
    else $error("access outside windows was forwarded");

  c_win_read: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_sdram_req && o_sdram_read_ahead);
  c_win_write: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_sdram_req && o_sdram_we);
  c_unmapped: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) o_host_unmapped);
  c_ra_off: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ra_dis_ff && o_sdram_req && !o_sdram_we);
  c_status_clear: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == hspm_pkg::OFS_STATUS && unmapped_seen_ff);
endmodule : hspm_mapper

// File: hspm_host_model.sv
// hspm_host_model: host cpu issuing single-cycle direct memory accesses
// assumes: shares the mapper's clock; the bench calls issue() for each access
module hspm_host_model (
  input wire logic i_clk,
  output logic o_req,
  output logic o_we,
  output logic [hspm_pkg::HOST_AW-1:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_req = 1'b0;
    o_we = 1'b0;
    o_addr = '0;
  end

  task automatic issue(input logic we, input logic [hspm_pkg::HOST_AW-1:0] addr);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_we <= we;
    o_addr <= addr;
    @(posedge i_clk);
    // released lines flip so a stale value never looks like a request
    o_req <= 1'b0;
    o_we <= ~we;
    o_addr <= ~addr;
  endtask : issue
endmodule : hspm_host_model

// File: test_host_sdram_page_mapper.sv
// test_host_sdram_page_mapper: self-checking bench of the page mapper
// assumes: single 100 mhz clock, synchronous reset, host model on the host port
module test_host_sdram_page_mapper;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_sys_clk, i_sys_rst, reg_wr, reg_rd, host_req, host_we;
  logic sdram_req, sdram_we, sdram_ra, host_unm;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [20:0] host_addr;
  logic [25:0] sdram_addr, last_addr;
  logic [7:0] base [4];
  logic ra_dis;
  logic [1:0] st_win;
  logic st_hit, st_unm;
  int err_count, num_checks, cyc;
  logic [7:0] offs [7] = '{8'h2c, 8'h2e, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38};
  logic [20:0] edges [10] = '{21'h0fffff, 21'h100000, 21'h13ffff, 21'h140000,
    21'h17ffff, 21'h180000, 21'h1bffff, 21'h1c0000, 21'h1fffff, 21'h000000};

  hspm_mapper hspm_mapper_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_host_req(host_req), .i_host_we(host_we),
    .i_host_addr(host_addr), .o_sdram_req(sdram_req), .o_sdram_we(sdram_we),
    .o_sdram_addr(sdram_addr), .o_sdram_read_ahead(sdram_ra), .o_host_unmapped(host_unm));

  hspm_host_model hspm_host_model_inst (.i_clk(i_sys_clk), .o_req(host_req),
    .o_we(host_we), .o_addr(host_addr));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("register read", {16'h0, e}, {16'h0, reg_rdata});
  endtask : rd_chk

  // expected sdram address: page base above the 18-bit window offset
  function automatic logic [25:0] exp_addr(input logic [20:0] a);
    return {base[a[19:18]], a[17:0]};
  endfunction : exp_addr

  task automatic host_chk(input logic we, input logic [20:0] a);
    logic hit;
    hit = a[20];
    hspm_host_model_inst.issue(we, a);
    #1;
    if (hit) last_addr = exp_addr(a);
    if (hit) st_win = a[19:18];
    st_hit = st_hit | hit;
    st_unm = st_unm | ~hit;
    chk("host flags", {28'h0, hit, hit & we, hit & ~we & ~ra_dis, ~hit},
      {28'h0, sdram_req, sdram_we, sdram_ra, host_unm});
    chk("sdram address", {6'h0, last_addr}, {6'h0, sdram_addr});
  endtask : host_chk

  initial begin
    i_sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    last_addr = 26'h0;
    ra_dis = 1'b0;
    st_win = 2'h0;
    st_hit = 1'b0;
    st_unm = 1'b0;
    void'($urandom(32'hffc7));
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(offs[i], 16'h0000);
    for (int w = 0; w < 4; w++) begin
      d = 16'($urandom);
      if (w == 3) d[9:2] = 8'hff;
      base[w] = d[9:2];
      wr(8'h30 + 8'(2 * w), d);
      rd_chk(8'h30 + 8'(2 * w), d & 16'h03fc);
    end
    wr(8'h50, 16'hffff);
    rd_chk(8'h50, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      ra_dis = k[0];
      wr(8'h38, {ra_dis, 15'h0});
      rd_chk(8'h38, {ra_dis, 15'h0});
      for (int i = 0; i < 10; i++) host_chk(i[0], edges[i]);
      for (int i = 0; i < 40; i++) host_chk(1'($urandom), 21'($urandom));
    end
    // status: last window, sticky hit, sticky miss cleared by this read
    rd_chk(8'h3a, {12'h000, st_unm, st_hit, st_win});
    st_unm = 1'b0;
    rd_chk(8'h3a, {12'h000, st_unm, st_hit, st_win});
    wrap_up();
  end
endmodule : test_host_sdram_page_mapper
